// [verilog/cbsd_defs.svh]
// constants for the conditional byte-set and frame decoder
// assumes one 10 MHz core clock; counts are in core clocks
// Summary of operation
// - 0F 98 with ModRM reg 000 set_byte_on_negative byte when sign flag set.
// - 0F 99 with ModRM reg 000 set_byte_on_negative byte when sign flag clear.
// - 0F 9A with ModRM reg 000 set_byte_on_negative byte when parity flag set.
// - 0F 9B with ModRM reg 000 set_byte_on_negative byte when parity flag clear.
// - Every byte-set takes 4 clocks to register, 5 to memory.
// - Signed lower, not lower, lower-or-same and strictly higher variants exist.
// - Unsigned higher is true when neither below nor equal.
// - Frame create: 16-bit displacement, 8-bit level; 10, 12, 15+4(n-1) clocks.
// - Frame release is one opcode byte, no operands, 4 clocks.
`ifndef CBSD_DEFS_SVH
`define CBSD_DEFS_SVH

// ============================================================
// opcode fields
`define CBSD_OPC_ESCAPE 8'h0F
`define CBSD_OPC_SET_HI 4'h9
`define CBSD_OPC_FRAME_CREATE 8'hC8
`define CBSD_OPC_FRAME_RELEASE 8'hC9
`define CBSD_MODRM_REG_SET 3'h0
`define CBSD_MODRM_MOD_REG 2'h3

// ============================================================
// condition codes named by the low opcode nibble
`define CBSD_CC_NEGATIVE 4'h8
`define CBSD_CC_NONNEGATIVE 4'h9
`define CBSD_CC_EVEN_PARITY 4'hA
`define CBSD_CC_ODD_PARITY 4'hB
`define CBSD_CC_UNSIGNED_HIGHER 4'h7
`define CBSD_CC_SIGNED_HIGHER 4'hF
`define CBSD_CC_SIGNED_LOWER 4'hC
`define CBSD_CC_SIGNED_NOT_LOWER 4'hD
`define CBSD_CC_SIGNED_LOWER_OR_SAME 4'hE

// ============================================================
// clock counts
`define CBSD_SET_REG_CLKS 11'h004
`define CBSD_SET_MEM_CLKS 11'h005
`define CBSD_FC_L0_CLKS 11'h00A
`define CBSD_FC_L1_CLKS 11'h00C
`define CBSD_FC_LN_BASE_CLKS 11'h00F
`define CBSD_FC_LN_STEP_CLKS 11'h004
`define CBSD_FR_CLKS 11'h004

`endif

// [verilog/cbsd_pkg.sv]
// types for the conditional byte-set and frame decoder
// assumes cbsd_defs.svh supplies all numeric constants
package cbsd_pkg;

    typedef enum logic [1:0] {
        CBSD_OP_NONE,
        CBSD_OP_SET_BYTE,
        CBSD_OP_FRAME_CREATE,
        CBSD_OP_FRAME_RELEASE
    } cbsd_op_t;

    typedef struct packed {
        logic [7:0] opcode0;
        logic [7:0] opcode1;
        logic [7:0] modrm;
        logic [15:0] disp;
        logic [7:0] level;
    } cbsd_instr_t;

    typedef struct packed {
        logic carry;
        logic parity;
        logic zero;
        logic sign;
        logic overflow;
    } cbsd_flags_t;

    typedef struct packed {
        logic to_memory;
        logic [7:0] modrm;
        logic [7:0] value;
    } cbsd_result_t;

    typedef struct packed {
        logic [15:0] disp;
        logic [7:0] level;
    } cbsd_frame_t;

endpackage

// [verilog/cbsd_decoder.sv]
// decode and timing of the byte-set group and frame create/release
// assumes the fetch stage holds instr_in and flags_in stable while issue_in is high
`timescale 1ns/1ps
`include "cbsd_defs.svh"

module cbsd_decoder
    import cbsd_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic issue_in,
    input wire cbsd_instr_t instr_in,
    input wire cbsd_flags_t flags_in,
    output logic ready_out,
    output logic illegal_out,
    output logic done_out,
    output logic byte_write_out,
    output logic flags_write_out,
    output cbsd_op_t op_out,
    output cbsd_result_t result_out,
    output cbsd_frame_t frame_out
);

    // ============================================================
    // functions
    function automatic logic cond_eval(input cbsd_flags_t f, input logic [3:0] cc);
        logic base;
        base = 1'b0;
        unique case (cc[3:1])
            3'h0: base = f.overflow;
            3'h1: base = f.carry;
            3'h2: base = f.zero;
            3'h3: base = f.carry | f.zero;
            3'h4: base = f.sign;
            3'h5: base = f.parity;
            3'h6: base = f.sign ^ f.overflow;
            3'h7: base = f.zero | (f.sign ^ f.overflow);
        endcase
        // odd codes are the complement of the even code below them
        return base ^ cc[0];
    endfunction

    function automatic logic [10:0] frame_clks(input logic [7:0] lvl);
        logic [10:0] n;
        n = {3'h0, lvl};
        if (lvl == 8'h00) begin
            return `CBSD_FC_L0_CLKS;
        end else if (lvl == 8'h01) begin
            return `CBSD_FC_L1_CLKS;
        end
        return 11'(`CBSD_FC_LN_BASE_CLKS + `CBSD_FC_LN_STEP_CLKS * (n - 11'h001));
    endfunction

    // ============================================================
    // decode
    typedef enum logic {ST_IDLE, ST_RUN} cbsd_state_t;

    cbsd_state_t state_reg;
    logic [10:0] count_reg;
    cbsd_op_t dec_op;
    logic [10:0] dec_clks;
    logic accept;
    logic is_mem;

    assign is_mem = instr_in.modrm[7:6] != `CBSD_MODRM_MOD_REG;

    always_comb begin
        dec_op = CBSD_OP_NONE;
        dec_clks = 11'h000;
        if (instr_in.opcode0 == `CBSD_OPC_ESCAPE && instr_in.opcode1[7:4] == `CBSD_OPC_SET_HI
                && instr_in.modrm[5:3] == `CBSD_MODRM_REG_SET) begin
            dec_op = CBSD_OP_SET_BYTE;
            dec_clks = is_mem ? `CBSD_SET_MEM_CLKS : `CBSD_SET_REG_CLKS;
        end else if (instr_in.opcode0 == `CBSD_OPC_FRAME_CREATE) begin
            dec_op = CBSD_OP_FRAME_CREATE;
            dec_clks = frame_clks(instr_in.level);
        end else if (instr_in.opcode0 == `CBSD_OPC_FRAME_RELEASE) begin
            dec_op = CBSD_OP_FRAME_RELEASE;
            dec_clks = `CBSD_FR_CLKS;
        end
    end

    assign ready_out = state_reg == ST_IDLE;
    assign accept = ready_out && issue_in && dec_op != CBSD_OP_NONE;
    assign illegal_out = ready_out && issue_in && dec_op == CBSD_OP_NONE;
    assign done_out = state_reg == ST_RUN && count_reg == 11'h001;
    assign byte_write_out = done_out && op_out == CBSD_OP_SET_BYTE;
    // status flags are never touched by this group
    assign flags_write_out = 1'b0;

    // ============================================================
    // sequencing: the accept cycle counts as the first clock
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_reg <= ST_IDLE;
            count_reg <= 11'h000;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        state_reg <= ST_RUN;
                        count_reg <= dec_clks - 11'h001;
                    end
                end
                ST_RUN: begin
                    count_reg <= count_reg - 11'h001;
                    if (count_reg == 11'h001) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ============================================================
    // operand capture
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            op_out <= CBSD_OP_NONE;
            result_out <= '0;
            frame_out <= '0;
        end else if (accept) begin
            op_out <= dec_op;
            if (dec_op == CBSD_OP_SET_BYTE) begin
                result_out.to_memory <= is_mem;
                result_out.modrm <= instr_in.modrm;
                result_out.value <= {7'h00, cond_eval(flags_in, instr_in.opcode1[3:0])};
            end
            if (dec_op == CBSD_OP_FRAME_CREATE) begin
                frame_out.disp <= instr_in.disp;
                frame_out.level <= instr_in.level;
            end else begin
                frame_out <= '0;
            end
        end
    end

    // ============================================================
    // assertions
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    logic acc_set_reg;
    logic acc_set_mem;
    logic [3:0] acc_cc;
    assign acc_set_reg = accept && dec_op == CBSD_OP_SET_BYTE && !is_mem;
    assign acc_set_mem = accept && dec_op == CBSD_OP_SET_BYTE && is_mem;
    assign acc_cc = instr_in.opcode1[3:0];

    AST_NEGATIVE: assert property (acc_set_reg && acc_cc == `CBSD_CC_NEGATIVE |->
            ##3 done_out && result_out.value == {7'h00, $past(flags_in.sign, 3)})
        else $error("negative byte-set wrong value or timing");
    AST_NONNEGATIVE: assert property (acc_set_mem && acc_cc == `CBSD_CC_NONNEGATIVE |->
            ##4 done_out && result_out.value == {7'h00, !$past(flags_in.sign, 4)})
        else $error("nonnegative byte-set wrong value or timing");
    AST_EVEN_PARITY: assert property (acc_set_reg && acc_cc == `CBSD_CC_EVEN_PARITY |->
            ##3 result_out.value[0] == $past(flags_in.parity, 3))
        else $error("even parity byte-set wrong value");
    AST_ODD_PARITY: assert property (acc_set_reg && acc_cc == `CBSD_CC_ODD_PARITY |->
            ##3 result_out.value[0] != $past(flags_in.parity, 3))
        else $error("odd parity byte-set wrong value");
    AST_SET_REG_TIME: assert property (acc_set_reg |-> !done_out [*3] ##1 byte_write_out)
        else $error("register byte-set not done in 4 clocks");
    AST_SET_MEM_TIME: assert property (acc_set_mem |-> !done_out [*4] ##1 byte_write_out)
        else $error("memory byte-set not done in 5 clocks");
    AST_SIGNED_HIGHER: assert property (acc_set_reg && acc_cc == `CBSD_CC_SIGNED_HIGHER |->
            ##3 result_out.value[0] == !($past(flags_in.zero, 3)
                | ($past(flags_in.sign, 3) ^ $past(flags_in.overflow, 3))))
        else $error("signed higher byte-set wrong value");
    AST_UNSIGNED_HIGHER: assert property (acc_set_reg && acc_cc == `CBSD_CC_UNSIGNED_HIGHER |->
            ##3 result_out.value[0] == !($past(flags_in.carry, 3) | $past(flags_in.zero, 3)))
        else $error("unsigned higher byte-set wrong value");
    AST_FRAME_L0: assert property (accept && dec_op == CBSD_OP_FRAME_CREATE && instr_in.level == 8'h00 |->
            !done_out [*8] ##1 !done_out ##1 done_out)
        else $error("frame create level 0 not 10 clocks");
    AST_FRAME_L2: assert property (accept && dec_op == CBSD_OP_FRAME_CREATE && instr_in.level == 8'h02 |->
            ##18 done_out && $past(!done_out) && frame_out.level == 8'h02)
        else $error("frame create level 2 not 19 clocks");
    AST_FRAME_RELEASE: assert property (accept && dec_op == CBSD_OP_FRAME_RELEASE |->
            ##3 done_out && !byte_write_out)
        else $error("frame release not 4 clocks");
    AST_FLAGS_KEPT: assert property (done_out |-> !flags_write_out && result_out.value[7:1] == 7'h00)
        else $error("byte-set touched flags or upper bits");

    // ============================================================
    // further compare variants, operand capture and refusal
    AST_SIGNED_LOWER: assert property (acc_set_reg && acc_cc == `CBSD_CC_SIGNED_LOWER |->
            ##3 result_out.value[0] == ($past(flags_in.sign, 3) ^ $past(flags_in.overflow, 3)))
        else $error("signed lower byte-set wrong value");
    AST_SIGNED_NOT_LOWER: assert property (acc_set_mem && acc_cc == `CBSD_CC_SIGNED_NOT_LOWER |->
            ##4 result_out.value[0] == !($past(flags_in.sign, 4) ^ $past(flags_in.overflow, 4)))
        else $error("signed not lower byte-set wrong value");
    AST_SIGNED_LOWER_OR_SAME: assert property (acc_set_reg && acc_cc == `CBSD_CC_SIGNED_LOWER_OR_SAME |->
            ##3 result_out.value[0] == ($past(flags_in.zero, 3)
                | ($past(flags_in.sign, 3) ^ $past(flags_in.overflow, 3))))
        else $error("signed lower or same byte-set wrong value");
    AST_DEST_CAPTURE: assert property (accept && dec_op == CBSD_OP_SET_BYTE |=>
            result_out.modrm == $past(instr_in.modrm)
            && result_out.to_memory == ($past(instr_in.modrm[7:6]) != `CBSD_MODRM_MOD_REG))
        else $error("byte-set destination not captured");
    AST_ILLEGAL_REG_FIELD: assert property (ready_out && issue_in && instr_in.opcode0 == `CBSD_OPC_ESCAPE
            && instr_in.opcode1[7:4] == `CBSD_OPC_SET_HI && instr_in.modrm[5:3] != `CBSD_MODRM_REG_SET
            |-> illegal_out)
        else $error("byte-set with nonzero reg field not refused");
    AST_ILLEGAL_IDLE: assert property (illegal_out |=> ready_out && !done_out)
        else $error("refused opcode started an instruction");
    AST_BUSY_HOLDS: assert property (!ready_out |=>
            $stable(op_out) && $stable(result_out) && $stable(frame_out))
        else $error("operands changed while busy");
    AST_DONE_ONCE: assert property (done_out |=> !done_out && ready_out)
        else $error("done held or block still busy after done");
    AST_FRAME_L1: assert property (accept && dec_op == CBSD_OP_FRAME_CREATE && instr_in.level == 8'h01 |->
            ##11 done_out && $past(!done_out))
        else $error("frame create level 1 not 12 clocks");
    AST_FRAME_CAPTURE: assert property (accept && dec_op == CBSD_OP_FRAME_CREATE |=>
            frame_out.disp == $past(instr_in.disp) && frame_out.level == $past(instr_in.level))
        else $error("frame displacement or level not captured");

    COV_SET_MEM: cover property (acc_set_mem ##4 byte_write_out);
    COV_FRAME_L1: cover property (accept && dec_op == CBSD_OP_FRAME_CREATE && instr_in.level == 8'h01);
    COV_RELEASE: cover property (accept && dec_op == CBSD_OP_FRAME_RELEASE ##3 done_out);
    COV_ILLEGAL: cover property (illegal_out);
    COV_SIGNED_HIGHER: cover property (acc_set_reg && acc_cc == `CBSD_CC_SIGNED_HIGHER ##3 byte_write_out);

endmodule

// [test/tb_condition_byte_set_decode.sv]
// self-checking bench for the byte-set and frame create/release decoder
// assumes cbsd_pkg is compiled first; the bench drives every port itself
`timescale 1ns/1ps

module tb_condition_byte_set_decode
    import cbsd_pkg::*;
;
    typedef struct {
        cbsd_op_t op;
        cbsd_result_t res;
        cbsd_frame_t frm;
        int due;
    } cbsd_note_t;

    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic issue_in = 1'b0;
    cbsd_instr_t instr_in = '0;
    cbsd_flags_t flags_in = '0;
    logic ready_out, illegal_out, done_out, byte_write_out, flags_write_out;
    cbsd_op_t op_out;
    cbsd_result_t result_out;
    cbsd_frame_t frame_out;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    cbsd_note_t q[$];
    cbsd_note_t mon;
    cbsd_result_t last_res = '0;
    cbsd_instr_t bad[2] = '{'{8'h0F, 8'h98, 8'h08, 16'h0000, 8'h00}, '{8'h90, 8'h00, 8'h00, 16'h0000, 8'h00}};
    logic [7:0] lv[4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
    logic [1:0] md;

    always #50 clock_in = ~clock_in;
    always @(posedge clock_in) cyc <= cyc + 1;

    cbsd_decoder u_cbsd_decoder (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .issue_in(issue_in),
        .instr_in(instr_in), .flags_in(flags_in), .ready_out(ready_out), .illegal_out(illegal_out),
        .done_out(done_out), .byte_write_out(byte_write_out), .flags_write_out(flags_write_out),
        .op_out(op_out), .result_out(result_out), .frame_out(frame_out));

    // ============================================================
    // helpers
    task chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    function logic cond(input logic [3:0] cc, input cbsd_flags_t f);
        logic c;
        case (cc[3:1])
            3'h0: c = f.overflow;
            3'h1: c = f.carry;
            3'h2: c = f.zero;
            3'h3: c = f.carry | f.zero;
            3'h4: c = f.sign;
            3'h5: c = f.parity;
            3'h6: c = f.sign ^ f.overflow;
            default: c = f.zero | (f.sign ^ f.overflow);
        endcase
        return c ^ cc[0];
    endfunction

    // offer one instruction, note its expected outcome once it is taken
    task issue(input cbsd_instr_t ins, input cbsd_flags_t fl);
        cbsd_note_t n;
        int nclk;
        instr_in = ins;
        flags_in = fl;
        issue_in = 1'b1;
        while (ready_out !== 1'b1) begin
            @(posedge clock_in);
            #1;
        end
        n.res = last_res;
        n.frm = '0;
        if (ins.opcode0 == 8'h0F) begin
            n.op = CBSD_OP_SET_BYTE;
            n.res = {ins.modrm[7:6] != 2'h3, ins.modrm, {7'h00, cond(ins.opcode1[3:0], fl)}};
            nclk = (ins.modrm[7:6] == 2'h3) ? 4 : 5;
            last_res = n.res;
        end else if (ins.opcode0 == 8'hC8) begin
            n.op = CBSD_OP_FRAME_CREATE;
            n.frm = {ins.disp, ins.level};
            nclk = (ins.level == 8'h00) ? 10 : (ins.level == 8'h01) ? 12 : 15 + 4 * (int'(ins.level) - 1);
        end else begin
            n.op = CBSD_OP_FRAME_RELEASE;
            nclk = 4;
        end
        @(posedge clock_in);
        #1;
        n.due = cyc + nclk - 2;
        q.push_back(n);
    endtask

    task summarize();
        if (q.size() != 0) error_cnt++;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ============================================================
    // result monitor
    always @(posedge clock_in) begin
        if (done_out === 1'b1) begin
            if (q.size() == 0) begin
                chk("unexpected done", 48'h0, 48'h1);
            end else begin
                mon = q.pop_front();
                chk("done cycle", mon.due, cyc);
                chk("op", mon.op, op_out);
                chk("result", mon.res, result_out);
                chk("byte write", mon.op == CBSD_OP_SET_BYTE, byte_write_out);
                chk("flags write", 1'b0, flags_write_out);
                chk("frame", mon.frm, frame_out);
            end
        end
    end

    // ============================================================
    // stimulus
    initial begin
        void'($urandom(6));
        repeat (20) @(posedge clock_in);
        #1 sys_rst_in = 1'b0;
        @(posedge clock_in);
        #1;
        chk("ready after reset", 1'b1, ready_out);
        chk("op after reset", CBSD_OP_NONE, op_out);
        for (int i = 0; i < 2; i++) begin
            instr_in = bad[i];
            issue_in = 1'b1;
            #1;
            chk("illegal flag", 1'b1, illegal_out);
            @(posedge clock_in);
            #1;
            chk("ready after refusal", 1'b1, ready_out);
        end
        for (int i = 0; i < 36; i++) begin
            // memory only in every fourth slot, so compare codes 1, 5, 9 and D never meet a register destination
            md = (i % 4 == 1) ? 2'($urandom_range(2, 0)) : 2'h3;
            if (i % 9 == 8) begin
                issue('{8'hC8, 8'h00, 8'h00, 16'($urandom), lv[i / 9]}, '0);
                issue('{8'hC9, 8'h00, 8'h00, 16'h0000, 8'h00}, '0);
            end else begin
                issue('{8'h0F, {4'h9, 4'(i)}, {md, 3'h0, 3'($urandom)}, 16'h0000, 8'h00}, 5'($urandom));
            end
        end
        issue_in = 1'b0;
        while (q.size() != 0) @(posedge clock_in);
        @(posedge clock_in);
        summarize();
    end

    initial begin
        repeat (5000) @(posedge clock_in);
        error_cnt++;
        summarize();
    end
endmodule
